// ---- rtl/t16h_defs.svh ----
`ifndef T16H_DEFS_SVH
`define T16H_DEFS_SVH

// Avalon register byte offsets of the controller
`define T16H_OFS_CMD        6'h00
`define T16H_OFS_STATUS     6'h04
`define T16H_OFS_PERIOD     6'h08
`define T16H_OFS_WIDTH      6'h0C
`define T16H_OFS_PRESCALE   6'h10
`define T16H_OFS_OUTCTL     6'h14
`define T16H_OFS_CAPCTL     6'h18
`define T16H_OFS_MODECTL    6'h1C
`define T16H_OFS_PORTCFG    6'h20

// Device register addresses on the device access port
`define T16H_DEV_CAPCTL     16'hFF6A
`define T16H_DEV_OUTCTL     16'hFF6B
`define T16H_DEV_PRESCALE   16'hFF7F
`define T16H_DEV_PORTDIR    16'hFF25
`define T16H_DEV_PORTLAT    16'hFF05
`define T16H_DEV_CMP1       16'hFF12
`define T16H_DEV_CMP2       16'hFF14
`define T16H_DEV_MODECTL    16'hFF60

// Output control field positions
`define T16H_OC_ENABLE      0
`define T16H_OC_CLR         2
`define T16H_OC_SET         3
`define T16H_OC_INV2        4
`define T16H_OC_ONESHOT     5
`define T16H_OC_TRIG        6

// Prescaler field positions
`define T16H_PS_CLK_LO      0
`define T16H_PS_CLK_HI      1
`define T16H_PS_A_LO        4
`define T16H_PS_A_HI        5
`define T16H_PS_B_LO        6
`define T16H_PS_B_HI        7

// Mode and capture control fields that touch the first input pin
`define T16H_MC_CS_HI       3
`define T16H_MC_CS_LO       2
`define T16H_CC_TRIG_A      1
`define T16H_CC_CAP2        2

// Port bits of the shared and first input pins
`define T16H_PIN_SHARED     4
`define T16H_PIN_FIRST      3

// Reset values
`define T16H_RST_PRESCALE   8'h00
`define T16H_RST_PORTDIR    8'hFF
`define T16H_RST_ZERO8      8'h00
`define T16H_RST_ZERO16     16'h0000
`define T16H_MODE_STOP      8'h00

// Trigger spacing in main clocks: two count clocks of each divided source, the 10-bit maximum for the pin
`define T16H_GAP_DIV2       10'h004
`define T16H_GAP_DIV4       10'h008
`define T16H_GAP_DIV256     10'h200
`define T16H_GAP_EXT        10'h3FF

`endif

// ---- rtl/t16h_pkg.sv ----
package t16h_pkg;

  typedef enum logic [2:0] {
    T16H_CMD_NONE     = 3'b000,
    T16H_CMD_INTERVAL = 3'b001,
    T16H_CMD_PULSE    = 3'b010,
    T16H_CMD_STOP     = 3'b011,
    T16H_CMD_ONESHOT  = 3'b100,
    T16H_CMD_INPUTS   = 3'b101
  } t16h_cmd_t;

  typedef enum logic [1:0] {
    T16H_ST_IDLE = 2'b00,
    T16H_ST_ISSUE = 2'b01,
    T16H_ST_WAIT = 2'b10
  } t16h_state_t;

endpackage

// ---- rtl/t16h_dev_port.sv ----
`timescale 1ns/1ps
`default_nettype none
`include "t16h_defs.svh"

// Device access: address and data settle one cycle before the strobe
module t16h_dev_port
  import t16h_pkg::*;
(
  input  wire logic        sys_clk_i,
  input  wire logic        rst_i,
  input  wire logic        req_i,
  input  wire logic [15:0] addr_i,
  input  wire logic [15:0] data_i,
  output logic      [15:0] dev_addr_o,
  output logic      [15:0] dev_wdata_o,
  output logic             dev_wr_o,
  output logic             done_o
);

  logic pend_reg;

  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      dev_addr_o  <= `T16H_RST_ZERO16;
      dev_wdata_o <= `T16H_RST_ZERO16;
    end else if (req_i && !pend_reg) begin
      dev_addr_o  <= addr_i;
      dev_wdata_o <= data_i;
    end
  end

  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      pend_reg <= 1'b0;
      dev_wr_o <= 1'b0;
      done_o   <= 1'b0;
    end else begin
      pend_reg <= req_i && !pend_reg && !dev_wr_o;
      dev_wr_o <= pend_reg;
      done_o   <= dev_wr_o;
    end
  end

endmodule
`default_nettype wire

// ---- rtl/t16h_ctrl.sv ----
// Decided for this implementation: the register offsets and register access over Avalon-MM.
`timescale 1ns/1ps
`default_nettype none
`include "t16h_defs.svh"

// Summary of operation
// - Trigger only while one-shot mode selected.
// - Trigger writes spaced two count clocks.
// - Enable output before set bit, separately.
// - Output control changed only while stopped.
// - External count pulses exceed two clocks.
// - Stop counter before writing prescaler.
// - Pin clock excludes pin clear or capture.
// - Port bits set per output or input use.
// - No compare rewrite while counter runs.
// - Interval setup order: capture, compare, clock, mode.
// - Pulse setup order ends with mode start.
// - Width strictly below period.
module t16h_ctrl
  import t16h_pkg::*;
(
  input  wire logic        sys_clk_i,
  input  wire logic        rst_i,
  input  wire logic [5:0]  avs_address_i,
  input  wire logic        avs_read_i,
  input  wire logic        avs_write_i,
  input  wire logic [31:0] avs_writedata_i,
  output logic      [31:0] avs_readdata_o,
  output logic             avs_waitrequest_o,
  output logic      [15:0] dev_addr_o,
  output logic      [15:0] dev_wdata_o,
  output logic             dev_wr_o
);

  logic [15:0] period_reg;
  logic [15:0] width_reg;
  logic [7:0]  prescale_reg;
  logic [7:0]  outctl_reg;
  logic [7:0]  capctl_reg;
  logic [7:0]  modectl_reg;
  logic [7:0]  portdir_reg;
  logic [7:0]  portlat_reg;
  t16h_cmd_t   cmd_reg;
  t16h_state_t state_reg;
  logic [3:0]  step_reg;
  logic        running_reg;
  logic [2:0]  err_reg;
  logic [9:0]  gap_reg;
  logic        req_reg;
  logic        done;
  logic        wr_acc;
  logic [15:0] step_addr;
  logic [15:0] step_data;
  logic        step_last;

  // Trigger spacing: two periods of the chosen divided count clock, or the 10-bit maximum for the pin clock, in main clocks
  function automatic logic [9:0] gap_for(input logic [1:0] sel);
    unique case (sel)
      2'b00:   gap_for = `T16H_GAP_DIV2;
      2'b01:   gap_for = `T16H_GAP_DIV4;
      2'b10:   gap_for = `T16H_GAP_DIV256;
      2'b11:   gap_for = `T16H_GAP_EXT; // Pin pulses may be slow, take the longest
    endcase
  endfunction

  // Prohibited edge code 10 is refused rather than sent to the device
  function automatic logic edge_bad(input logic [7:0] ps);
    edge_bad = ({ps[`T16H_PS_B_HI], ps[`T16H_PS_B_LO]} == 2'b10) ||
               ({ps[`T16H_PS_A_HI], ps[`T16H_PS_A_LO]} == 2'b10);
  endfunction

  // Write sequences, one step per index: {last, address, data}
  function automatic logic [32:0] step_of(input t16h_cmd_t c, input logic [3:0] i);
    logic [7:0] oc_noset;
    oc_noset = outctl_reg & ~(8'h01 << `T16H_OC_SET) & ~(8'h01 << `T16H_OC_TRIG);
    step_of = {1'b1, `T16H_DEV_MODECTL, 8'h00, `T16H_MODE_STOP};
    unique case (c)
      T16H_CMD_INTERVAL: begin
        unique case (i)
          4'h0: step_of = {1'b0, `T16H_DEV_MODECTL, 8'h00, `T16H_MODE_STOP};
          4'h1: step_of = {1'b0, `T16H_DEV_CAPCTL, 8'h00, capctl_reg};
          4'h2: step_of = {1'b0, `T16H_DEV_CMP1, period_reg};
          4'h3: step_of = {1'b0, `T16H_DEV_PRESCALE, 8'h00, prescale_reg};
          default: step_of = {1'b1, `T16H_DEV_MODECTL, 8'h00, modectl_reg};
        endcase
      end
      T16H_CMD_PULSE: begin
        unique case (i)
          4'h0: step_of = {1'b0, `T16H_DEV_MODECTL, 8'h00, `T16H_MODE_STOP};
          4'h1: step_of = {1'b0, `T16H_DEV_PORTLAT, 8'h00,
                           portlat_reg & ~(8'h01 << `T16H_PIN_SHARED)};
          4'h2: step_of = {1'b0, `T16H_DEV_PORTDIR, 8'h00,
                           portdir_reg & ~(8'h01 << `T16H_PIN_SHARED)};
          4'h3: step_of = {1'b0, `T16H_DEV_CAPCTL, 8'h00, capctl_reg};
          4'h4: step_of = {1'b0, `T16H_DEV_CMP1, period_reg};
          4'h5: step_of = {1'b0, `T16H_DEV_CMP2, width_reg};
          4'h6: step_of = {1'b0, `T16H_DEV_OUTCTL, 8'h00, oc_noset};
          4'h7: step_of = {1'b0, `T16H_DEV_OUTCTL, 8'h00,
                           outctl_reg & ~(8'h01 << `T16H_OC_TRIG)};
          4'h8: step_of = {1'b0, `T16H_DEV_PRESCALE, 8'h00, prescale_reg};
          default: step_of = {1'b1, `T16H_DEV_MODECTL, 8'h00, modectl_reg};
        endcase
      end
      T16H_CMD_INPUTS: begin
        unique case (i)
          4'h0: step_of = {1'b0, `T16H_DEV_MODECTL, 8'h00, `T16H_MODE_STOP};
          4'h1: step_of = {1'b0, `T16H_DEV_PORTDIR, 8'h00, portdir_reg |
                           (8'h01 << `T16H_PIN_SHARED) |
                           (8'h01 << `T16H_PIN_FIRST)};
          default: step_of = {1'b1, `T16H_DEV_PRESCALE, 8'h00, prescale_reg};
        endcase
      end
      T16H_CMD_ONESHOT:
        step_of = {1'b1, `T16H_DEV_OUTCTL, 8'h00,
                   outctl_reg | (8'h01 << `T16H_OC_TRIG)};
      T16H_CMD_STOP:
        step_of = {1'b1, `T16H_DEV_MODECTL, 8'h00, `T16H_MODE_STOP};
      T16H_CMD_NONE:
        step_of = {1'b1, `T16H_DEV_MODECTL, 8'h00, `T16H_MODE_STOP};
      default:
        step_of = {1'b1, `T16H_DEV_MODECTL, 8'h00, `T16H_MODE_STOP};
    endcase
  endfunction

  // Pin as count clock must not also clear, start or capture
  function automatic logic pin_conflict(input logic [7:0] ps, input logic [7:0] mc,
                                        input logic [7:0] cc);
    pin_conflict = ({ps[`T16H_PS_CLK_HI], ps[`T16H_PS_CLK_LO]} == 2'b11) &&
                   (({mc[`T16H_MC_CS_HI], mc[`T16H_MC_CS_LO]} == 2'b10) ||
                    cc[`T16H_CC_TRIG_A] || cc[`T16H_CC_CAP2]);
  endfunction

  assign wr_acc    = avs_write_i && !avs_waitrequest_o;

  always_comb begin
    logic [32:0] s;
    s = step_of(cmd_reg, step_reg);
    step_last = s[32];
    step_addr = s[31:16];
    step_data = s[15:0];
  end

  // One wait cycle per access, then the answer for exactly one cycle
  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      avs_waitrequest_o <= 1'b1;
    end else begin
      avs_waitrequest_o <= !((avs_read_i || avs_write_i) && avs_waitrequest_o);
    end
  end

  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      avs_readdata_o <= 32'h00000000;
    end else if ((avs_read_i || avs_write_i) && avs_waitrequest_o) begin
      unique case (avs_address_i)
        `T16H_OFS_STATUS:   avs_readdata_o <= {25'h0000000, err_reg, running_reg,
                                               gap_reg != 10'h000, state_reg};
        `T16H_OFS_PERIOD:   avs_readdata_o <= {16'h0000, period_reg};
        `T16H_OFS_WIDTH:    avs_readdata_o <= {16'h0000, width_reg};
        `T16H_OFS_PRESCALE: avs_readdata_o <= {24'h000000, prescale_reg};
        `T16H_OFS_OUTCTL:   avs_readdata_o <= {24'h000000, outctl_reg};
        `T16H_OFS_CAPCTL:   avs_readdata_o <= {24'h000000, capctl_reg};
        `T16H_OFS_MODECTL:  avs_readdata_o <= {24'h000000, modectl_reg};
        `T16H_OFS_PORTCFG:  avs_readdata_o <= {16'h0000, portlat_reg, portdir_reg};
        default:            avs_readdata_o <= 32'h00000000;
      endcase
    end
  end

  // Shadow copies: sequences read these, so edits mid-sequence are dropped
  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      period_reg   <= `T16H_RST_ZERO16;
      width_reg    <= `T16H_RST_ZERO16;
      prescale_reg <= `T16H_RST_PRESCALE;
      outctl_reg   <= `T16H_RST_ZERO8;
      capctl_reg   <= `T16H_RST_ZERO8;
      modectl_reg  <= `T16H_RST_ZERO8;
      portdir_reg  <= `T16H_RST_PORTDIR;
      portlat_reg  <= `T16H_RST_ZERO8;
    end else if (wr_acc && state_reg == T16H_ST_IDLE) begin
      unique case (avs_address_i)
        `T16H_OFS_PERIOD:   period_reg   <= avs_writedata_i[15:0];
        `T16H_OFS_WIDTH:    width_reg    <= avs_writedata_i[15:0];
        `T16H_OFS_PRESCALE: prescale_reg <= avs_writedata_i[7:0];
        `T16H_OFS_OUTCTL:   outctl_reg   <= avs_writedata_i[7:0];
        `T16H_OFS_CAPCTL:   capctl_reg   <= avs_writedata_i[7:0];
        `T16H_OFS_MODECTL:  modectl_reg  <= avs_writedata_i[7:0];
        `T16H_OFS_PORTCFG: begin
          portdir_reg <= avs_writedata_i[7:0];
          portlat_reg <= avs_writedata_i[15:8];
        end
        default: ;
      endcase
    end
  end

  // Command acceptance and write sequencing
  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      state_reg <= T16H_ST_IDLE;
      cmd_reg   <= T16H_CMD_NONE;
      step_reg  <= 4'h0;
      req_reg   <= 1'b0;
      err_reg   <= 3'b000;
    end else begin
      unique case (state_reg)
        T16H_ST_IDLE: begin
          if (wr_acc && avs_address_i == `T16H_OFS_CMD) begin
            err_reg <= 3'b000;
            if (avs_writedata_i[2:0] == T16H_CMD_ONESHOT &&
                !outctl_reg[`T16H_OC_ONESHOT]) begin
              err_reg <= 3'b001;
            end else if (avs_writedata_i[2:0] == T16H_CMD_ONESHOT &&
                         gap_reg != 10'h000) begin
              err_reg <= 3'b010;
            end else if (avs_writedata_i[2:0] == T16H_CMD_PULSE &&
                         width_reg >= period_reg) begin
              err_reg <= 3'b011;
            end else if ((avs_writedata_i[2:0] == T16H_CMD_INTERVAL ||
                          avs_writedata_i[2:0] == T16H_CMD_PULSE ||
                          avs_writedata_i[2:0] == T16H_CMD_INPUTS) &&
                         edge_bad(prescale_reg)) begin
              err_reg <= 3'b100;
            end else if ((avs_writedata_i[2:0] == T16H_CMD_INTERVAL ||
                          avs_writedata_i[2:0] == T16H_CMD_PULSE) &&
                         pin_conflict(prescale_reg, modectl_reg, capctl_reg)) begin
              err_reg <= 3'b101;
            end else if (avs_writedata_i[2:0] >= 3'b001 &&
                         avs_writedata_i[2:0] <= 3'b101) begin
              cmd_reg   <= t16h_cmd_t'(avs_writedata_i[2:0]);
              step_reg  <= 4'h0;
              state_reg <= T16H_ST_ISSUE;
            end else begin
              err_reg <= 3'b110;
            end
          end
        end
        T16H_ST_ISSUE: begin
          req_reg   <= 1'b1;
          state_reg <= T16H_ST_WAIT;
        end
        T16H_ST_WAIT: begin
          req_reg <= 1'b0;
          if (done) begin
            if (step_last) begin
              state_reg <= T16H_ST_IDLE;
            end else begin
              step_reg  <= step_reg + 4'h1;
              state_reg <= T16H_ST_ISSUE;
            end
          end
        end
        default: state_reg <= T16H_ST_IDLE;
      endcase
    end
  end

  // Running as far as the host has commanded the device
  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      running_reg <= 1'b0;
    end else if (state_reg == T16H_ST_WAIT && done) begin
      if (step_addr == `T16H_DEV_MODECTL) begin
        running_reg <= step_data[7:0] != `T16H_MODE_STOP;
      end
    end
  end

  // Spacing between successive software triggers
  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      gap_reg <= 10'h000;
    end else if (state_reg == T16H_ST_WAIT && done && cmd_reg == T16H_CMD_ONESHOT) begin
      gap_reg <= gap_for({prescale_reg[`T16H_PS_CLK_HI],
                          prescale_reg[`T16H_PS_CLK_LO]});
    end else if (gap_reg != 10'h000) begin
      gap_reg <= gap_reg - 10'h001;
    end
  end

  t16h_dev_port u_dev_port (
    .sys_clk_i   (sys_clk_i),
    .rst_i       (rst_i),
    .req_i       (req_reg),
    .addr_i      (step_addr),
    .data_i      (step_data),
    .dev_addr_o  (dev_addr_o),
    .dev_wdata_o (dev_wdata_o),
    .dev_wr_o    (dev_wr_o),
    .done_o      (done)
  );

endmodule
`default_nettype wire

// ---- tb/t16h_ctrl_asserts.sv ----
`timescale 1ns/1ps
`default_nettype none
`include "t16h_defs.svh"

module t16h_ctrl_chk
  import t16h_pkg::*;
(
  input wire logic        sys_clk_i,
  input wire logic        rst_i,
  input wire logic [5:0]  avs_address_i,
  input wire logic        avs_read_i,
  input wire logic        avs_write_i,
  input wire logic [31:0] avs_writedata_i,
  input wire logic [31:0] avs_readdata_o,
  input wire logic        avs_waitrequest_o,
  input wire logic [15:0] dev_addr_o,
  input wire logic [15:0] dev_wdata_o,
  input wire logic        dev_wr_o
);
  logic        run_reg;
  logic        en_reg;
  logic [7:0]  oc_reg;
  logic [7:0]  ps_reg;
  logic [15:0] per_reg;
  logic [9:0]  gap_reg;
  logic [9:0]  need;
  logic        oc_wr;
  logic        trig_wr;

  default clocking cb @(posedge sys_clk_i);
  endclocking
  default disable iff (rst_i);

  assign oc_wr   = dev_wr_o && dev_addr_o == `T16H_DEV_OUTCTL;
  assign trig_wr = oc_wr && dev_wdata_o[`T16H_OC_TRIG];

  always_comb begin
    case (ps_reg[1:0])
      2'b00:   need = `T16H_GAP_DIV2;
      2'b01:   need = `T16H_GAP_DIV4;
      2'b10:   need = `T16H_GAP_DIV256;
      default: need = `T16H_GAP_EXT;
    endcase
  end

  // Shadow of what the device last received
  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      run_reg <= 1'b0;
      en_reg  <= 1'b0;
      oc_reg  <= 8'h00;
      ps_reg  <= 8'h00;
      per_reg <= 16'hFFFF;
    end else if (dev_wr_o) begin
      if (dev_addr_o == `T16H_DEV_MODECTL) run_reg <= dev_wdata_o[7:0] != 8'h00;
      if (oc_wr) en_reg <= dev_wdata_o[`T16H_OC_ENABLE];
      if (oc_wr) oc_reg <= dev_wdata_o[7:0];
      if (dev_addr_o == `T16H_DEV_PRESCALE) ps_reg <= dev_wdata_o[7:0];
      if (dev_addr_o == `T16H_DEV_CMP1) per_reg <= dev_wdata_o;
    end
  end

  // Saturates so the first trigger after reset is never flagged
  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) gap_reg <= 10'h3FF;
    else if (trig_wr) gap_reg <= 10'h000;
    else if (gap_reg != 10'h3FF) gap_reg <= gap_reg + 10'h001;
  end

  wait_one_a: assert property ((avs_read_i || avs_write_i) && avs_waitrequest_o
    |=> !avs_waitrequest_o) else $error("waitrequest not low one cycle after request");
  wait_pulse_a: assert property (!avs_waitrequest_o |=> avs_waitrequest_o)
    else $error("waitrequest low longer than one cycle");
  ack_cause_a: assert property (!avs_waitrequest_o |-> $past(avs_read_i || avs_write_i))
    else $error("answer without request");
  unmap_zero_a: assert property (avs_read_i && !avs_waitrequest_o && avs_address_i > 6'h20
    |-> avs_readdata_o == 32'h0) else $error("unmapped read not zero");
  wr_space_a: assert property (dev_wr_o |=> !dev_wr_o [*3])
    else $error("device writes closer than four cycles");
  addr_setup_a: assert property (dev_wr_o |-> $stable(dev_addr_o) && $stable(dev_wdata_o))
    else $error("device address or data not set up");
  set_after_en_a: assert property (oc_wr && dev_wdata_o[`T16H_OC_SET] |-> en_reg)
    else $error("set bit before output enable");
  trig_mode_a: assert property (trig_wr |-> dev_wdata_o[`T16H_OC_ONESHOT])
    else $error("trigger outside one-shot mode");
  trig_gap_a: assert property (trig_wr |-> gap_reg >= need)
    else $error("triggers too close");
  oc_stopped_a: assert property (oc_wr && run_reg
    |-> (dev_wdata_o[7:0] & 8'hAF) == (oc_reg & 8'hAF)) else $error("output control changed running");
  ps_stopped_a: assert property (dev_wr_o && dev_addr_o == `T16H_DEV_PRESCALE
    |-> !run_reg && dev_wdata_o[7:6] != 2'b10 && dev_wdata_o[5:4] != 2'b10)
    else $error("bad prescaler write");
  cmp_stopped_a: assert property (dev_wr_o && dev_addr_o == `T16H_DEV_CMP1 |-> !run_reg)
    else $error("period rewritten while running");
  width_below_a: assert property (dev_wr_o && dev_addr_o == `T16H_DEV_CMP2
    |-> dev_wdata_o < per_reg) else $error("width not below period");
endmodule

bind t16h_ctrl t16h_ctrl_chk u_chk (.sys_clk_i(sys_clk_i), .rst_i(rst_i),
  .avs_address_i(avs_address_i), .avs_read_i(avs_read_i), .avs_write_i(avs_write_i),
  .avs_writedata_i(avs_writedata_i), .avs_readdata_o(avs_readdata_o),
  .avs_waitrequest_o(avs_waitrequest_o), .dev_addr_o(dev_addr_o),
  .dev_wdata_o(dev_wdata_o), .dev_wr_o(dev_wr_o));
`default_nettype wire

// ---- tb/t16h_dev_model.sv ----
`timescale 1ns/1ps
`default_nettype none
`include "t16h_defs.svh"

module t16h_dev_model (
  input wire logic        sys_clk_i,
  input wire logic        rst_i,
  input wire logic [15:0] dev_addr_i,
  input wire logic [15:0] dev_wdata_i,
  input wire logic        dev_wr_i
);
  logic [7:0]  ps_reg;
  logic [7:0]  dir_reg;
  logic [7:0]  oc_reg;
  logic [7:0]  mode_reg;
  logic [15:0] cmp1_reg;
  logic [15:0] cmp2_reg;
  logic        ff_reg;
  logic [15:0] log_q[$];
  int          misuse;
  logic        out_pin;

  // Pin drives only as output with enable, else low
  assign out_pin = oc_reg[`T16H_OC_ENABLE] & ff_reg & ~dir_reg[`T16H_PIN_SHARED];

  always @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      ps_reg   <= `T16H_RST_PRESCALE;
      dir_reg  <= `T16H_RST_PORTDIR;
      oc_reg   <= 8'h00;
      mode_reg <= 8'h00;
      cmp1_reg <= 16'hFFFF;
      cmp2_reg <= 16'h0000;
      ff_reg   <= 1'b0;
      misuse   = 0;
    end else if (dev_wr_i) begin
      log_q.push_back(dev_addr_i);
      case (dev_addr_i)
        `T16H_DEV_PRESCALE: begin
          if (mode_reg != 8'h00) misuse++;
          ps_reg <= dev_wdata_i[7:0];
        end
        `T16H_DEV_OUTCTL: begin
          if (dev_wdata_i[6] && !dev_wdata_i[5]) misuse++;
          if (dev_wdata_i[3] && !oc_reg[0]) misuse++;
          if (dev_wdata_i[3]) ff_reg <= 1'b1;
          else if (dev_wdata_i[2]) ff_reg <= 1'b0;
          oc_reg <= dev_wdata_i[7:0] & 8'hB3;
        end
        `T16H_DEV_CMP1: begin
          if (mode_reg != 8'h00) misuse++;
          cmp1_reg <= dev_wdata_i;
        end
        `T16H_DEV_CMP2: begin
          if (dev_wdata_i >= cmp1_reg) misuse++;
          cmp2_reg <= dev_wdata_i;
        end
        `T16H_DEV_PORTDIR: dir_reg <= dev_wdata_i[7:0];
        `T16H_DEV_MODECTL: mode_reg <= dev_wdata_i[7:0]; // Nonzero starts counting
        default: ;
      endcase
    end
  end
endmodule
`default_nettype wire

// ---- tb/tb_top.sv ----
`timescale 1ns/1ps
`default_nettype none
`include "t16h_defs.svh"

module tb_top
  import t16h_pkg::*;
;
  logic        sys_clk_i = 1'b0;
  logic        rst_i = 1'b1;
  logic [5:0]  adr = 6'h00;
  logic        rd = 1'b0;
  logic        wr = 1'b0;
  logic [31:0] wd = 32'h0;
  logic [31:0] rdata;
  logic        wreq;
  logic [15:0] daddr;
  logic [15:0] dwdata;
  logic        dwr;
  logic [31:0] d;
  logic [15:0] exp_log[10];
  logic [7:0]  tp[7] = '{8'h80, 8'h20, 8'h03, 8'h03, 8'h03, 8'h00, 8'hD3};
  logic [7:0]  tc[7] = '{8'h00, 8'h00, 8'h02, 8'h04, 8'h00, 8'h00, 8'h00};
  logic [7:0]  tm[7] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h08, 8'h00, 8'h00};
  logic [2:0]  te[7] = '{3'd4, 3'd4, 3'd5, 3'd5, 3'd5, 3'd0, 3'd0};
  int          n_fail = 0;
  int          samples_checked = 0;

  always #12.5 sys_clk_i = ~sys_clk_i;

  t16h_ctrl DUT (.sys_clk_i(sys_clk_i), .rst_i(rst_i), .avs_address_i(adr),
    .avs_read_i(rd), .avs_write_i(wr), .avs_writedata_i(wd), .avs_readdata_o(rdata),
    .avs_waitrequest_o(wreq), .dev_addr_o(daddr), .dev_wdata_o(dwdata), .dev_wr_o(dwr));
  t16h_dev_model u_dev (.sys_clk_i(sys_clk_i), .rst_i(rst_i), .dev_addr_i(daddr),
    .dev_wdata_i(dwdata), .dev_wr_i(dwr));

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    samples_checked++;
    if (g !== e) begin
      n_fail++;
      $display("BAD %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic av_wr(input logic [5:0] a, input logic [31:0] v);
    @(posedge sys_clk_i);
    adr <= a;
    wd <= v;
    wr <= 1'b1;
    do @(posedge sys_clk_i); while (wreq !== 1'b0);
    wr <= 1'b0;
  endtask

  task automatic av_rd(input logic [5:0] a, output logic [31:0] v);
    @(posedge sys_clk_i);
    adr <= a;
    rd <= 1'b1;
    do @(posedge sys_clk_i); while (wreq !== 1'b0);
    v = rdata;
    rd <= 1'b0;
  endtask

  // Polls until the sequence is over, then checks the error code
  task automatic run(input t16h_cmd_t c, input logic [2:0] e);
    logic [31:0] s;
    s = 32'h1;
    av_wr(`T16H_OFS_CMD, {29'h0, c});
    for (int i = 0; i < 300 && s[1:0] !== 2'b00; i++) av_rd(`T16H_OFS_STATUS, s);
    chk("state", 32'h0, {30'h0, s[1:0]});
    chk("err", {29'h0, e}, {29'h0, s[6:4]});
  endtask

  task automatic chk_log(input int n);
    chk("log length", n, u_dev.log_q.size());
    for (int i = 0; i < n && i < u_dev.log_q.size(); i++) chk("log addr", exp_log[i], u_dev.log_q[i]);
    u_dev.log_q.delete();
  endtask

  task automatic end_sim;
    $display("compares %0d mismatches %0d", samples_checked, n_fail);
    if (n_fail == 0 && samples_checked > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask

  initial begin
    repeat (40000) @(posedge sys_clk_i);
    n_fail++;
    $display("BAD watchdog expected done seen hang");
    end_sim;
  end

  initial begin
    repeat (2) @(posedge sys_clk_i);
    rst_i <= 1'b0;
    av_rd(`T16H_OFS_PRESCALE, d);
    chk("prescale", 32'h0, d);
    av_rd(`T16H_OFS_PORTCFG, d);
    chk("portcfg", 32'hFF, d);
    av_rd(6'h3C, d);
    chk("unmapped", 32'h0, d);
    chk("dev dir", 8'hFF, u_dev.dir_reg);
    $display("test reset done");
    av_wr(`T16H_OFS_PERIOD, 32'h0010);
    av_wr(`T16H_OFS_PRESCALE, 32'h01);
    av_wr(`T16H_OFS_MODECTL, 32'h0C);
    av_wr(`T16H_OFS_CMD, {29'h0, T16H_CMD_INTERVAL});
    av_wr(`T16H_OFS_PERIOD, 32'h1234);
    run(T16H_CMD_NONE, 3'd0);
    av_rd(`T16H_OFS_PERIOD, d);
    chk("period kept", 32'h0010, d);
    exp_log = '{16'hFF60, 16'hFF6A, 16'hFF12, 16'hFF7F, 16'hFF60, 0, 0, 0, 0, 0};
    chk_log(5);
    chk("cmp1", 16'h0010, u_dev.cmp1_reg);
    $display("test interval done");
    av_wr(`T16H_OFS_WIDTH, 32'h0010);
    run(T16H_CMD_PULSE, 3'd3);
    av_wr(`T16H_OFS_WIDTH, 32'h0004);
    av_wr(`T16H_OFS_OUTCTL, 32'h49);
    av_wr(`T16H_OFS_PRESCALE, 32'h02);
    u_dev.log_q.delete();
    run(T16H_CMD_PULSE, 3'd0);
    exp_log = '{16'hFF60, 16'hFF05, 16'hFF25, 16'hFF6A, 16'hFF12, 16'hFF14, 16'hFF6B,
                16'hFF6B, 16'hFF7F, 16'hFF60};
    chk_log(10);
    chk("dir", 8'hEF, u_dev.dir_reg);
    chk("oc", 8'h01, u_dev.oc_reg);
    chk("cmp2", 16'h0004, u_dev.cmp2_reg);
    chk("out pin", 1'b1, u_dev.out_pin);
    run(T16H_CMD_ONESHOT, 3'd1);
    av_wr(`T16H_OFS_OUTCTL, 32'h21);
    run(T16H_CMD_PULSE, 3'd0);
    u_dev.log_q.delete();
    run(T16H_CMD_ONESHOT, 3'd0);
    exp_log[0] = 16'hFF6B;
    chk_log(1);
    run(T16H_CMD_ONESHOT, 3'd2);
    repeat (600) @(posedge sys_clk_i);
    run(T16H_CMD_ONESHOT, 3'd0);
    $display("test pulse done");
    run(T16H_CMD_STOP, 3'd0);
    chk("mode", 8'h00, u_dev.mode_reg);
    av_wr(`T16H_OFS_PORTCFG, 32'h0);
    for (int i = 0; i < 7; i++) begin
      av_wr(`T16H_OFS_PRESCALE, {24'h0, tp[i]});
      av_wr(`T16H_OFS_CAPCTL, {24'h0, tc[i]});
      av_wr(`T16H_OFS_MODECTL, {24'h0, tm[i]});
      // Pin clock conflicts are judged on start commands, which carry capture setup
      run(te[i] == 3'd5 ? T16H_CMD_INTERVAL : T16H_CMD_INPUTS, te[i]);
      if (te[i] == 3'd0) chk("ps", tp[i], u_dev.ps_reg);
    end
    chk("dir in", 8'h18, u_dev.dir_reg);
    run(t16h_cmd_t'(3'b111), 3'd6);
    run(T16H_CMD_STOP, 3'd0);
    chk("misuse", 0, u_dev.misuse);
    $display("test inputs done");
    end_sim;
  end
endmodule
`default_nettype wire
